// *** inc/pss_pkg.sv ***
package pss_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned REQ_FAULT_MS    = 20;
    localparam int unsigned REQ_FAULT_CYC   = REQ_FAULT_MS * (CLK_HZ / 1000);
    localparam int unsigned FAULT_DWELL_CYC = 400_000;
    localparam int unsigned INIT_TMO_CYC    = 4_000_000;
    localparam int unsigned RST_DELAY_CYC   = 200;
    localparam int unsigned SEVERE_LIMIT    = 3;
    localparam int unsigned CNT_W           = 24;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned NSOFT       = 4;
    localparam logic [4:0]  CTRL_RST    = 5'h00;
    localparam logic [3:0]  EVT_RST     = 4'h0;
    localparam logic [3:0]  EVT_LOCK_KEEP = 4'h3;

    // ------------------------------------------------------------
    // event bit positions in the cause register
    // ------------------------------------------------------------
    localparam int unsigned EV_SEVERE = 0;
    localparam int unsigned EV_INIT   = 1;
    localparam int unsigned EV_REPEAT = 2;
    localparam int unsigned EV_REQ    = 3;

    // ------------------------------------------------------------
    // control bit positions
    // ------------------------------------------------------------
    localparam int unsigned CB_SEC  = 0;
    localparam int unsigned CB_UP   = 1;
    localparam int unsigned CB_MON1 = 2;
    localparam int unsigned CB_MON2 = 3;
    localparam int unsigned CB_WWD  = 4;

    // operating states
    typedef enum logic [1:0] {
        PSS_ACTIVE,
        PSS_FAULT,
        PSS_LOCKED,
        PSS_DISABLED
    } pss_state_t;

    // pending target after a FAULT dwell
    typedef enum logic [1:0] {
        PSS_TGT_ACTIVE,
        PSS_TGT_LOCKED,
        PSS_TGT_DISABLED
    } pss_tgt_t;

endpackage

// *** rtl/pss_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-stage level synchroniser
module pss_sync (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    // level in and out
    input  wire logic d_i,
    output logic      q_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic s1;   // first stage, read only by s2
        logic s2;   // second stage
    } pss_sync_st_t;

    pss_sync_st_t st_reg;   // registered state
    pss_sync_st_t st_next;  // next state

    // shift
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = d_i;
        st_next.s2 = st_reg.s1;
    end

    // register
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.s2;
endmodule
`default_nettype wire

// *** rtl/pss_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
// operating-state controller
module pss_seq
    import pss_pkg::*;
#(
    parameter int unsigned FAULT_DWELL = FAULT_DWELL_CYC,
    parameter int unsigned INIT_TMO    = INIT_TMO_CYC,
    parameter int unsigned REQ_DWELL   = REQ_FAULT_CYC,
    parameter int unsigned SEVERE_MAX  = SEVERE_LIMIT
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    // pins
    input  wire logic             programming_mode_pin_i,
    input  wire logic             enable_input_i,
    input  wire logic             enable_edge_mode_i,
    // host SPI decoded commands (one-cycle pulses)
    input  wire logic             spi_valid_i,
    input  wire logic             spi_req_disable_i,
    input  wire logic             spi_req_lock_i,
    input  wire logic             spi_ctrl_we_i,
    input  wire logic [4:0]       spi_ctrl_i,
    input  wire logic             wwd_serviced_i,
    // fault events (one-cycle pulses)
    input  wire logic             severe_fault_i,
    input  wire logic [NSOFT-1:0] volt_soft_fault_i,
    input  wire logic             mcu_mon_fault_i,
    input  wire logic             wwd_overflow_i,
    input  wire logic             irq_event_i,
    // state and controls
    output pss_state_t            state_o,
    output logic                  mcu_reset_output_o,
    output logic                  primary_step_down_en_o,
    output logic                  secondary_step_down_en_o,
    output logic                  step_up_rail_en_o,
    output logic                  ext_rail_monitor_one_en_o,
    output logic                  ext_rail_monitor_two_en_o,
    output logic                  window_watchdog_en_o,
    output logic                  irq_o,
    output logic                  prog_mode_o,
    output logic [3:0]            event_o,
    output logic [1:0]            severe_count_o
);
    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        pss_state_t       state;      // operating state
        pss_tgt_t         tgt;        // target after FAULT dwell
        logic [CNT_W-1:0] dwell;      // FAULT dwell counter
        logic [CNT_W-1:0] rst_cnt;    // reset hold counter
        logic [CNT_W-1:0] init_cnt;   // startup timer
        logic             init_run;   // startup timer running
        logic             got_spi;    // valid SPI seen
        logic             got_wwd;    // watchdog serviced
        logic             init_once;  // first expiry done
        logic [NSOFT-1:0] soft_seen;  // soft faults seen once
        logic             mon_once;   // monitor fault seen once
        logic [1:0]       sev_cnt;    // severe faults count
        logic [4:0]       ctrl;       // switchable functions
        logic [3:0]       evt;        // cause record
        logic             ena_d;      // enable input delayed
        logic             irq;        // interrupt pulse
        logic             started;    // power-on done
    } pss_seq_st_t;

    pss_seq_st_t st_reg;   // registered state
    pss_seq_st_t st_next;  // next state

    logic prog_sync;      // synchronised programming pin
    logic ena_event;      // valid enable event

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    pss_sync u_prog_sync (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .d_i    (programming_mode_pin_i),
        .q_o    (prog_sync)
    );

    // enable event: rising edge in edge mode, level otherwise
    assign ena_event = enable_edge_mode_i ?
                       (enable_input_i && !st_reg.ena_d) : enable_input_i;

    // count width cast
    function automatic logic [CNT_W-1:0] cw(input int unsigned v);
        return v[CNT_W-1:0];
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic soft_rst;   // soft reset this cycle
        logic severe;     // severe fault this cycle
        soft_rst = 1'b0;
        severe   = 1'b0;
        st_next  = st_reg;
        st_next.ena_d = enable_input_i;
        st_next.irq   = irq_event_i;
        if (st_reg.rst_cnt != '0) begin
            st_next.rst_cnt = st_reg.rst_cnt - cw(1);
        end
        unique case (st_reg.state)
            PSS_ACTIVE: begin
                // first cycle after power-on starts with reset held
                if (!st_reg.started) begin
                    st_next.started = 1'b1;
                    st_next.rst_cnt = cw(RST_DELAY_CYC);
                end
                // startup timer starts on reset release
                if (st_reg.rst_cnt == cw(1)) begin
                    st_next.init_run = 1'b1;
                    st_next.init_cnt = '0;
                    st_next.got_spi  = 1'b0;
                    st_next.got_wwd  = 1'b0;
                end
                if (spi_valid_i) begin
                    st_next.got_spi = 1'b1;
                end
                if (wwd_serviced_i) begin
                    st_next.got_wwd = 1'b1;
                end
                if (st_reg.init_run && st_reg.got_spi && st_reg.got_wwd) begin
                    st_next.init_run = 1'b0;
                end
                // startup timer, disabled in programming mode
                if (prog_sync) begin
                    st_next.init_cnt = '0;
                end else if (st_reg.init_run && st_reg.rst_cnt == '0) begin
                    st_next.init_cnt = st_reg.init_cnt + cw(1);
                    if (st_reg.init_cnt == cw(INIT_TMO - 1)) begin
                        st_next.init_run = 1'b0;
                        st_next.evt[EV_INIT] = 1'b1;
                        if (st_reg.init_once) begin
                            severe = 1'b1;
                        end else begin
                            st_next.init_once = 1'b1;
                            soft_rst = 1'b1;
                        end
                    end
                end
                // voltage soft faults: repeat escalates
                for (int i = 0; i < NSOFT; i++) begin
                    if (volt_soft_fault_i[i]) begin
                        if (st_reg.soft_seen[i]) begin
                            severe = 1'b1;
                            st_next.evt[EV_REPEAT] = 1'b1;
                        end else begin
                            st_next.soft_seen[i] = 1'b1;
                            soft_rst = 1'b1;
                        end
                    end
                end
                // MCU-monitor faults masked in programming mode
                if (mcu_mon_fault_i && !prog_sync) begin
                    if (st_reg.mon_once) begin
                        severe = 1'b1;
                        st_next.evt[EV_REPEAT] = 1'b1;
                    end else begin
                        st_next.mon_once = 1'b1;
                        soft_rst = 1'b1;
                    end
                end
                // watchdog overflow never escalates
                if (wwd_overflow_i && !prog_sync) begin
                    soft_rst = 1'b1;
                end
                if (severe_fault_i) begin
                    severe = 1'b1;
                end
                // SPI control of switchable functions
                if (spi_ctrl_we_i) begin
                    st_next.ctrl = spi_ctrl_i;
                end
                if (soft_rst) begin
                    st_next.rst_cnt  = cw(RST_DELAY_CYC);
                    st_next.init_run = 1'b0;
                end
                // state changes; state machine ignores programming mode
                if (severe) begin
                    st_next.state = PSS_FAULT;
                    st_next.tgt   = PSS_TGT_ACTIVE;
                    st_next.dwell = cw(FAULT_DWELL);
                    st_next.evt[EV_SEVERE] = 1'b1;
                    if (st_reg.sev_cnt != 2'h3) begin
                        st_next.sev_cnt = st_reg.sev_cnt + 2'h1;
                    end
                end else if (spi_req_disable_i || spi_req_lock_i) begin
                    st_next.state = PSS_FAULT;
                    st_next.tgt   = spi_req_lock_i ? PSS_TGT_LOCKED
                                                   : PSS_TGT_DISABLED;
                    st_next.dwell = cw(REQ_DWELL);
                    st_next.evt[EV_REQ] = 1'b1;
                end
                if (st_next.state != PSS_ACTIVE) begin
                    // keep event record and severe count; clear controls, reset hold, startup run and fault history
                    st_next.ctrl      = CTRL_RST;
                    st_next.init_run  = 1'b0;
                    st_next.init_once = 1'b0;
                    st_next.soft_seen = '0;
                    st_next.mon_once  = 1'b0;
                    st_next.rst_cnt   = '0;
                end
            end
            PSS_FAULT: begin
                if (st_reg.dwell != '0) begin
                    st_next.dwell = st_reg.dwell - cw(1);
                end
                if (st_reg.tgt == PSS_TGT_ACTIVE
                    && {30'h0, st_reg.sev_cnt} >= SEVERE_MAX
                    && (enable_edge_mode_i || !enable_input_i)) begin
                    st_next.state = PSS_LOCKED;
                    st_next.evt   = st_reg.evt & EVT_LOCK_KEEP;
                end else if (st_reg.dwell == cw(1)) begin
                    unique case (st_reg.tgt)
                        PSS_TGT_LOCKED: begin
                            st_next.state = PSS_LOCKED;
                            st_next.evt   = st_reg.evt & EVT_LOCK_KEEP;
                        end
                        PSS_TGT_DISABLED: begin
                            st_next.state   = PSS_DISABLED;
                            st_next.evt     = EVT_RST;
                            st_next.sev_cnt = '0;
                        end
                        default: begin
                            st_next.state   = PSS_ACTIVE;
                            st_next.rst_cnt = cw(RST_DELAY_CYC);
                        end
                    endcase
                end
            end
            PSS_LOCKED, PSS_DISABLED: begin
                if (ena_event) begin
                    st_next.state   = PSS_ACTIVE;
                    st_next.rst_cnt = cw(RST_DELAY_CYC);
                    st_next.sev_cnt = '0;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_reg       <= '0;
            st_reg.state <= PSS_ACTIVE;
            st_reg.tgt   <= PSS_TGT_ACTIVE;
            st_reg.ctrl  <= CTRL_RST;
            st_reg.evt   <= EVT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic act;  // in ACTIVE
    assign act = (st_reg.state == PSS_ACTIVE);

    assign state_o = st_reg.state;
    // reset high only in ACTIVE after delay
    assign mcu_reset_output_o = act && st_reg.started
                                && st_reg.rst_cnt == '0;
    assign primary_step_down_en_o    = act;
    assign secondary_step_down_en_o  = act && !st_reg.ctrl[CB_SEC];
    assign step_up_rail_en_o         = act && !st_reg.ctrl[CB_UP];
    assign ext_rail_monitor_one_en_o = act && !st_reg.ctrl[CB_MON1];
    assign ext_rail_monitor_two_en_o = act && !st_reg.ctrl[CB_MON2];
    assign window_watchdog_en_o      = act && !st_reg.ctrl[CB_WWD];
    assign irq_o          = st_reg.irq;
    assign prog_mode_o    = prog_sync;
    assign event_o        = st_reg.evt;
    assign severe_count_o = st_reg.sev_cnt;
endmodule
`default_nettype wire

// *** test/pss_seq_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker for the operating-state controller
// ------------------------------------------------------------
module pss_seq_chk
    import pss_pkg::*;
#(
    parameter int unsigned FAULT_DWELL = 20,
    parameter int unsigned INIT_TMO    = 50,
    parameter int unsigned REQ_DWELL   = 30,
    parameter int unsigned SEVERE_MAX  = 3
) (
    // clock and reset
    input wire logic             mclk_i,
    input wire logic             rstn_i,
    // watched inputs
    input wire logic             spi_req_disable_i,
    input wire logic             spi_req_lock_i,
    input wire logic             spi_ctrl_we_i,
    input wire logic [4:0]       spi_ctrl_i,
    input wire logic             severe_fault_i,
    input wire logic [NSOFT-1:0] volt_soft_fault_i,
    input wire logic             mcu_mon_fault_i,
    input wire logic             irq_event_i,
    // watched outputs
    input wire pss_state_t       state_o,
    input wire logic             mcu_reset_output_o,
    input wire logic             primary_step_down_en_o,
    input wire logic             secondary_step_down_en_o,
    input wire logic             step_up_rail_en_o,
    input wire logic             ext_rail_monitor_one_en_o,
    input wire logic             ext_rail_monitor_two_en_o,
    input wire logic             window_watchdog_en_o,
    input wire logic             irq_o,
    input wire logic             prog_mode_o,
    input wire logic [3:0]       event_o,
    input wire logic [1:0]       severe_count_o
);
    localparam int DW_HI = FAULT_DWELL + 4;   // fault dwell bound
    localparam int RQ_HI = REQ_DWELL + 4;     // request dwell bound
    localparam logic [1:0] SEV_LAST = 2'(SEVERE_MAX - 1);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    wire logic act = (state_o == PSS_ACTIVE);  // in ACTIVE
    // no competing event this cycle
    wire logic quiet = !severe_fault_i && volt_soft_fault_i == 4'h0
                       && !spi_req_lock_i && !spi_req_disable_i;
    // switchable functions, control bit order
    wire logic [4:0] ctl = {window_watchdog_en_o, ext_rail_monitor_two_en_o,
                            ext_rail_monitor_one_en_o, step_up_rail_en_o,
                            secondary_step_down_en_o};

    // request and severe entry sequences
    sequence s_lock;
        act && spi_req_lock_i && !severe_fault_i;
    endsequence
    sequence s_dis;
        act && spi_req_disable_i && !severe_fault_i;
    endsequence
    sequence s_sev;
        act && severe_fault_i && severe_count_o < SEV_LAST;
    endsequence

    a_all_off: assert property (!act |-> ctl == 5'h00
        && !primary_step_down_en_o && !mcu_reset_output_o)
        else $error("functions on outside active");
    a_primary_track: assert property (primary_step_down_en_o == act)
        else $error("primary rail mismatch");
    a_irq_follow: assert property (irq_event_i |=> irq_o)
        else $error("interrupt missing");
    a_severe_entry: assert property (act && severe_fault_i |=>
        state_o == PSS_FAULT && event_o[EV_SEVERE])
        else $error("severe fault not taken");
    a_fault_dwell: assert property (s_sev |=>
        (state_o == PSS_FAULT)[*8] ##[1:DW_HI] state_o == PSS_ACTIVE)
        else $error("fault dwell wrong");
    a_req_lock: assert property (s_lock |=>
        (state_o == PSS_FAULT)[*8] ##[1:RQ_HI] state_o == PSS_LOCKED)
        else $error("lock request path wrong");
    a_req_disable: assert property (s_dis |=>
        (state_o == PSS_FAULT)[*8] ##[1:RQ_HI] state_o == PSS_DISABLED)
        else $error("disable request path wrong");
    a_prog_mask: assert property (prog_mode_o && act && quiet &&
        mcu_reset_output_o && mcu_mon_fault_i |=> mcu_reset_output_o)
        else $error("monitor reset not masked");
    a_mon_reset: assert property (!prog_mode_o && act &&
        mcu_mon_fault_i |=> !mcu_reset_output_o)
        else $error("monitor reset missing");
    a_reset_stand: assert property ($fell(mcu_reset_output_o) |=>
        !mcu_reset_output_o[*8])
        else $error("reset pulse too short");
    a_ctrl_write: assert property (act && quiet && spi_ctrl_we_i |=>
        !act || ctl == ~$past(spi_ctrl_i))
        else $error("control write lost");
endmodule

bind pss_seq pss_seq_chk #(.FAULT_DWELL(FAULT_DWELL), .INIT_TMO(INIT_TMO),
    .REQ_DWELL(REQ_DWELL), .SEVERE_MAX(SEVERE_MAX)) u_chk (
    .mclk_i, .rstn_i, .spi_req_disable_i, .spi_req_lock_i, .spi_ctrl_we_i,
    .spi_ctrl_i, .severe_fault_i, .volt_soft_fault_i, .mcu_mon_fault_i,
    .irq_event_i, .state_o, .mcu_reset_output_o, .primary_step_down_en_o,
    .secondary_step_down_en_o, .step_up_rail_en_o, .ext_rail_monitor_one_en_o,
    .ext_rail_monitor_two_en_o, .window_watchdog_en_o, .irq_o, .prog_mode_o,
    .event_o, .severe_count_o);
`default_nettype wire

// *** test/pss_host_mdl.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host controller: configures and services after reset release
// ------------------------------------------------------------
module pss_host_mdl (
    // clock
    input  wire logic mclk_i,
    // device side
    input  wire logic rst_rel_i,
    // scenario controls
    input  wire logic serve_i,
    input  wire logic slow_i,
    // answers to the device
    output logic      spi_valid_o,
    output logic      wwd_serviced_o
);
    logic       rel_q = 1'b0;   // last reset level
    logic       busy  = 1'b0;   // serving after a release
    logic [7:0] cnt   = 8'h00;  // cycles since release
    initial spi_valid_o = 1'b0;
    initial wwd_serviced_o = 1'b0;
    // one SPI frame, then one watchdog service, per release
    always @(posedge mclk_i) begin
        rel_q <= rst_rel_i;
        spi_valid_o <= 1'b0;
        wwd_serviced_o <= 1'b0;
        if (rst_rel_i !== 1'b1) begin
            busy <= 1'b0;
        end else if (!rel_q && serve_i) begin
            busy <= 1'b1;
            cnt <= 8'h00;
        end else if (busy) begin
            cnt <= cnt + 8'h01;
            if (cnt == (slow_i ? 8'h28 : 8'h02)) spi_valid_o <= 1'b1;
            if (cnt == (slow_i ? 8'h2A : 8'h04)) begin
                wwd_serviced_o <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/tb_pss_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_pss_seq;
    import pss_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed nets
    // ------------------------------------------------------------
    localparam int FD = 20;    // shortened fault dwell
    localparam int IT = 50;    // shortened startup window
    localparam int RD = 30;    // shortened request dwell
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        pin = 1'b0, ena = 1'b0, edge_md = 1'b0;
    logic [4:0]  ctrl = 5'h00;       // control write value
    logic [10:0] pv = 11'h000;       // pulse inputs
    logic        serve = 1'b1, slow = 1'b1;
    wire logic   spi_v, wwd_s, rst_o, irq, prog, prim;
    wire logic [4:0] en;             // switchable functions
    wire logic [3:0] ev;
    wire logic [1:0] sc;
    pss_state_t  st;
    int          n_errors = 0, total_checks = 0, cyc = 0;
    // ordinary cases: control value, expected enables
    logic [9:0]  tbl [4] = '{{5'h1F, 5'h00}, {5'h15, 5'h0A},
                             {5'h0A, 5'h15}, {5'h00, 5'h1F}};

    pss_seq #(.FAULT_DWELL(FD), .INIT_TMO(IT), .REQ_DWELL(RD),
              .SEVERE_MAX(3)) uut (
        .mclk_i, .rstn_i, .programming_mode_pin_i(pin),
        .enable_input_i(ena), .enable_edge_mode_i(edge_md),
        .spi_valid_i(spi_v), .spi_req_disable_i(pv[4]),
        .spi_req_lock_i(pv[5]), .spi_ctrl_we_i(pv[6]), .spi_ctrl_i(ctrl),
        .wwd_serviced_i(wwd_s), .severe_fault_i(pv[0]),
        .volt_soft_fault_i(pv[10:7]), .mcu_mon_fault_i(pv[1]),
        .wwd_overflow_i(pv[2]), .irq_event_i(pv[3]), .state_o(st),
        .mcu_reset_output_o(rst_o), .primary_step_down_en_o(prim),
        .secondary_step_down_en_o(en[0]), .step_up_rail_en_o(en[1]),
        .ext_rail_monitor_one_en_o(en[2]), .ext_rail_monitor_two_en_o(en[3]),
        .window_watchdog_en_o(en[4]), .irq_o(irq), .prog_mode_o(prog),
        .event_o(ev), .severe_count_o(sc));
    pss_host_mdl host (.mclk_i, .rst_rel_i(rst_o), .serve_i(serve),
        .slow_i(slow), .spi_valid_o(spi_v), .wwd_serviced_o(wwd_s));

    // clock and hang guard
    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string nm);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // one-cycle pulse, outputs settled on return
    task automatic pulse(input int b);
        @(posedge mclk_i);
        pv[b] <= 1'b1;
        @(posedge mclk_i);
        pv <= 11'h000;
        #1;
    endtask
    task automatic wait_st(input pss_state_t s, input int lim);
        for (int i = 0; i < lim && st !== s; i++) idle(1);
        chk(8'(st), 8'(s), "state");
    endtask
    task automatic wait_rst(input logic v, input int lim);
        for (int i = 0; i < lim && rst_o !== v; i++) idle(1);
        chk({7'h00, rst_o}, {7'h00, v}, "reset output");
    endtask
    task automatic set_ena(input logic v);
        @(posedge mclk_i);
        ena <= v;
        idle(2);
    endtask
    task automatic do_reset();
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        idle(3);
        chk(8'(st), 8'(PSS_ACTIVE), "reset state");
        chk({7'h00, prim}, 8'h01, "reset primary");
        @(posedge mclk_i);
        rstn_i <= 1'b1;
        wait_rst(1'b1, 300);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        foreach (tbl[i]) begin
            @(posedge mclk_i);
            ctrl <= tbl[i][9:5];
            pulse(6);
            chk({3'h0, en}, {3'h0, tbl[i][4:0]}, "enables");
        end
        slow = 1'b0;
        pulse(3);
        chk({7'h00, irq}, 8'h01, "irq");
        pulse(1);
        wait_rst(1'b1, 300);
        for (int k = 0; k < 2; k++) begin
            pulse(2);
            chk(8'(st), 8'(PSS_ACTIVE), "overflow state");
            wait_rst(1'b1, 300);
        end
        @(posedge mclk_i);
        pin <= 1'b1;
        serve <= 1'b0;
        idle(4);
        chk({7'h00, prog}, 8'h01, "prog mode");
        pulse(1);
        pulse(2);
        chk({7'h00, rst_o}, 8'h01, "masked reset");
        pulse(7);
        chk({7'h00, rst_o}, 8'h00, "volt reset");
        wait_rst(1'b1, 300);
        idle(3 * IT);
        chk(8'(st), 8'(PSS_ACTIVE), "prog hold");
        chk({7'h00, rst_o}, 8'h01, "prog no reset");
        @(posedge mclk_i);
        pin <= 1'b0;
        wait_rst(1'b0, IT + 10);
        chk(8'(st), 8'(PSS_ACTIVE), "first expiry");
        wait_rst(1'b1, 300);
        wait_st(PSS_FAULT, IT + 10);
        chk({7'h00, ev[EV_INIT]}, 8'h01, "init event");
        serve = 1'b1;
        wait_st(PSS_ACTIVE, FD + 10);
        wait_rst(1'b1, 300);
        pulse(9);
        wait_rst(1'b1, 300);
        pulse(9);
        chk(8'(st), 8'(PSS_FAULT), "repeat fault");
        do_reset();
        for (int k = 0; k < 3; k++) begin
            wait_rst(1'b1, 300);
            pulse(0);
            chk(8'(st), 8'(PSS_FAULT), "severe");
            chk({6'h00, sc}, 8'(k + 1), "severe count");
            wait_st(k < 2 ? PSS_ACTIVE : PSS_LOCKED, FD + 10);
        end
        chk({4'h0, ev & ~EVT_LOCK_KEEP}, 8'h00, "locked events");
        chk({7'h00, ev[EV_SEVERE]}, 8'h01, "locked cause");
        set_ena(1'b1);
        chk(8'(st), 8'(PSS_ACTIVE), "lock exit");
        set_ena(1'b0);
        wait_rst(1'b1, 300);
        @(posedge mclk_i);
        ctrl <= 5'h1F;
        pulse(6);
        pulse(4);
        chk(8'(st), 8'(PSS_FAULT), "req fault");
        wait_st(PSS_DISABLED, RD + 10);
        chk({4'h0, ev}, 8'h00, "disabled events");
        pulse(6);
        set_ena(1'b1);
        chk(8'(st), 8'(PSS_ACTIVE), "enable wake");
        chk({3'h0, en}, 8'h1F, "ctrl cleared");
        set_ena(1'b0);
        @(posedge mclk_i);
        pin <= 1'b1;
        edge_md <= 1'b1;
        pulse(5);
        wait_st(PSS_LOCKED, RD + 20);
        set_ena(1'b1);
        chk(8'(st), 8'(PSS_ACTIVE), "edge wake");
        print_verdict();
    end
endmodule
`default_nettype wire
